// *** rtl/counter16_pkg.sv ***
// Constants, register map and types for the 16-bit counter with input capture
package counter16_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] ADDR_CONTROL_A       = 6'h00;
  localparam logic [5:0] ADDR_CONTROL_B       = 6'h04;
  localparam logic [5:0] ADDR_COUNT_LOW       = 6'h08;
  localparam logic [5:0] ADDR_COUNT_HIGH      = 6'h0c;
  localparam logic [5:0] ADDR_CAPTURE_LOW     = 6'h10;
  localparam logic [5:0] ADDR_CAPTURE_HIGH    = 6'h14;
  localparam logic [5:0] ADDR_COMPARE_A_LOW   = 6'h18;
  localparam logic [5:0] ADDR_COMPARE_A_HIGH  = 6'h1c;
  localparam logic [5:0] ADDR_COMPARE_B_LOW   = 6'h20;
  localparam logic [5:0] ADDR_COMPARE_B_HIGH  = 6'h24;
  localparam logic [5:0] ADDR_IRQ_MASK        = 6'h28;
  localparam logic [5:0] ADDR_IRQ_FLAGS       = 6'h2c;
  localparam logic [5:0] ADDR_COMPARATOR_CTRL = 6'h30;

  // Field positions
  localparam int CTRL_A_WGM_LSB      = 0;
  localparam int CTRL_B_CS_LSB       = 0;
  localparam int CTRL_B_WGM_LSB      = 3;
  localparam int CTRL_B_EDGE_BIT     = 6;
  localparam int CTRL_B_FILTER_BIT   = 7;
  localparam int IRQ_OVERFLOW_BIT    = 0;
  localparam int IRQ_CAPTURE_BIT     = 5;
  localparam int COMPARATOR_SEL_BIT  = 2;

  // Reset values
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [31:0] READ_ZERO   = 32'h00000000;

  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIRECT   = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam logic [9:0] PRESCALE_MASK_8    = 10'h007;
  localparam logic [9:0] PRESCALE_MASK_64   = 10'h03f;
  localparam logic [9:0] PRESCALE_MASK_256  = 10'h0ff;
  localparam logic [9:0] PRESCALE_MASK_1024 = 10'h3ff;

  // Counter landmarks
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TOP_10BIT    = 16'h03ff;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;

  // Noise filter depth: samples that must agree
  localparam int FILTER_SAMPLES = 4;

  // Waveform modes
  localparam logic [3:0] MODE_NORMAL       = 4'h0;
  localparam logic [3:0] MODE_PC_8BIT      = 4'h1;
  localparam logic [3:0] MODE_PC_9BIT      = 4'h2;
  localparam logic [3:0] MODE_PC_10BIT     = 4'h3;
  localparam logic [3:0] MODE_CTC_COMPARE  = 4'h4;
  localparam logic [3:0] MODE_FAST_8BIT    = 4'h5;
  localparam logic [3:0] MODE_FAST_9BIT    = 4'h6;
  localparam logic [3:0] MODE_FAST_10BIT   = 4'h7;
  localparam logic [3:0] MODE_PFC_CAPTURE  = 4'h8;
  localparam logic [3:0] MODE_PFC_COMPARE  = 4'h9;
  localparam logic [3:0] MODE_PC_CAPTURE   = 4'ha;
  localparam logic [3:0] MODE_PC_COMPARE   = 4'hb;
  localparam logic [3:0] MODE_CTC_CAPTURE  = 4'hc;
  localparam logic [3:0] MODE_FAST_CAPTURE = 4'he;
  localparam logic [3:0] MODE_FAST_COMPARE = 4'hf;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avalon_req_s;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_e;

  // Modes whose count limit is the capture register
  function automatic logic mode_capture_top(input logic [3:0] mode);
    return (mode == MODE_PFC_CAPTURE) || (mode == MODE_PC_CAPTURE) ||
           (mode == MODE_CTC_CAPTURE) || (mode == MODE_FAST_CAPTURE);
  endfunction

  // Up/down counting modes
  function automatic logic mode_dual(input logic [3:0] mode);
    return (mode == MODE_PC_8BIT) || (mode == MODE_PC_9BIT) || (mode == MODE_PC_10BIT) ||
           (mode == MODE_PFC_CAPTURE) || (mode == MODE_PFC_COMPARE) ||
           (mode == MODE_PC_CAPTURE) || (mode == MODE_PC_COMPARE);
  endfunction

  // Single-slope modes that flag overflow at the limit
  function automatic logic mode_fast(input logic [3:0] mode);
    return (mode == MODE_FAST_8BIT) || (mode == MODE_FAST_9BIT) ||
           (mode == MODE_FAST_10BIT) || (mode == MODE_FAST_CAPTURE) ||
           (mode == MODE_FAST_COMPARE);
  endfunction

  function automatic logic [15:0] mode_top(input logic [3:0] mode, input logic [15:0] cmp_a,
                                           input logic [15:0] cap);
    case (mode)
      MODE_PC_8BIT, MODE_FAST_8BIT:   return TOP_8BIT;
      MODE_PC_9BIT, MODE_FAST_9BIT:   return TOP_9BIT;
      MODE_PC_10BIT, MODE_FAST_10BIT: return TOP_10BIT;
      MODE_CTC_COMPARE, MODE_PFC_COMPARE, MODE_PC_COMPARE, MODE_FAST_COMPARE: return cmp_a;
      MODE_PFC_CAPTURE, MODE_PC_CAPTURE, MODE_CTC_CAPTURE, MODE_FAST_CAPTURE: return cap;
      default:                        return COUNT_MAX;
    endcase
  endfunction

endpackage

// *** rtl/counter16_input_capture.sv ***
// 16-bit up/down counter with shared high-byte holding register and input capture
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - high-byte writes go to holding register; compare high reads bypass it
// - low-byte counter read copies high byte
// - low-byte counter write loads high from holding
// - clock select zero stops the counter
// - counter accessible whether clock runs or not
// - processor write beats count operations
// - mode field sets clear, up, down
// - overflow flag set per mode
// - selected source edge triggers capture
// - capture copies counter, sets flag together
// - enabled flag requests interrupt, service clears
// - writing one clears capture flag
// - capture low read fills holding register
// - capture writable only in capture-limit modes
// - select bit routes comparator to capture
// - source switch may capture; software clears
// - filter needs four equal samples
// - filter enable bit, system clock, four cycles
// - captures suppressed in capture-limit modes
// - later capture overwrites unread value
// - software-driven pin edge also captures
// - one holding register for all wide registers
// - bottom is 0x0000, maximum is 0xffff
module counter16_input_capture
  import counter16_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire avalon_req_s bus_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire logic        capture_pin_i,
  input  wire logic        comparator_output_i,
  input  wire logic        external_clock_i,
  input  wire logic        capture_irq_ack_i,
  input  wire logic        overflow_irq_ack_i,
  output logic             capture_irq_o,
  output logic             overflow_irq_o
);

  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic [7:0]  comparator_control_status;
  logic [7:0]  irq_mask;
  logic [15:0] timer_count;
  logic [15:0] capture_value;
  logic [15:0] compare_a;
  logic [15:0] compare_b;
  logic [7:0]  holding;
  logic [7:0]  snap_high;
  logic        overflow_flag;
  logic        capture_flag;
  count_dir_e  direction;

  logic [2:0]  clock_select_field;
  logic [3:0]  waveform_mode_field;
  logic        capture_filter_enable;
  logic        capture_edge_rising;
  logic        comparator_capture_select;
  logic        capture_irq_enable;
  logic        overflow_irq_enable;

  assign clock_select_field        = timer_control_b[CTRL_B_CS_LSB +: 3];
  assign waveform_mode_field       = {timer_control_b[CTRL_B_WGM_LSB +: 2],
                                      timer_control_a[CTRL_A_WGM_LSB +: 2]};
  assign capture_filter_enable     = timer_control_b[CTRL_B_FILTER_BIT];
  assign capture_edge_rising       = timer_control_b[CTRL_B_EDGE_BIT];
  assign comparator_capture_select = comparator_control_status[COMPARATOR_SEL_BIT];
  assign capture_irq_enable        = irq_mask[IRQ_CAPTURE_BIT];
  assign overflow_irq_enable       = irq_mask[IRQ_OVERFLOW_BIT];

  // Bus handshake: one wait state, the access takes effect at the edge that
  // sees waitrequest low, so read data are settled a full cycle before.
  logic access;
  logic do_write;
  logic do_read;
  logic wr_byte;

  assign access   = (bus_i.read || bus_i.write) && !waitrequest_o;
  assign do_write = access && bus_i.write;
  assign do_read  = access && bus_i.read;
  assign wr_byte  = do_write && bus_i.byteenable[0];

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      waitrequest_o <= 1'b1;
    end else if (access) begin
      waitrequest_o <= 1'b1;
    end else if (bus_i.read || bus_i.write) begin
      waitrequest_o <= 1'b0;
    end
  end

  // Read data and a snapshot of the matching high byte are taken together,
  // so the holding register later receives the same word that was returned.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      readdata_o <= READ_ZERO;
      snap_high  <= BYTE_RESET;
    end else if (bus_i.read && waitrequest_o) begin
      readdata_o <= READ_ZERO;
      snap_high  <= BYTE_RESET;
      case (bus_i.address)
        ADDR_CONTROL_A:       readdata_o[7:0] <= timer_control_a;
        ADDR_CONTROL_B:       readdata_o[7:0] <= timer_control_b;
        ADDR_COUNT_LOW: begin
          readdata_o[7:0] <= timer_count[7:0];
          snap_high       <= timer_count[15:8];
        end
        ADDR_COUNT_HIGH:      readdata_o[7:0] <= holding;
        ADDR_CAPTURE_LOW: begin
          readdata_o[7:0] <= capture_value[7:0];
          snap_high       <= capture_value[15:8];
        end
        ADDR_CAPTURE_HIGH:    readdata_o[7:0] <= holding;
        ADDR_COMPARE_A_LOW:   readdata_o[7:0] <= compare_a[7:0];
        ADDR_COMPARE_A_HIGH:  readdata_o[7:0] <= compare_a[15:8];
        ADDR_COMPARE_B_LOW:   readdata_o[7:0] <= compare_b[7:0];
        ADDR_COMPARE_B_HIGH:  readdata_o[7:0] <= compare_b[15:8];
        ADDR_IRQ_MASK:        readdata_o[7:0] <= irq_mask;
        ADDR_IRQ_FLAGS: begin
          readdata_o[IRQ_OVERFLOW_BIT] <= overflow_flag;
          readdata_o[IRQ_CAPTURE_BIT]  <= capture_flag;
        end
        ADDR_COMPARATOR_CTRL: readdata_o[7:0] <= comparator_control_status;
        default:              readdata_o <= READ_ZERO;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      timer_control_a           <= BYTE_RESET;
      timer_control_b           <= BYTE_RESET;
      irq_mask                  <= BYTE_RESET;
      comparator_control_status <= BYTE_RESET;
    end else if (wr_byte) begin
      case (bus_i.address)
        ADDR_CONTROL_A:       timer_control_a <= bus_i.writedata[7:0];
        ADDR_CONTROL_B:       timer_control_b <= bus_i.writedata[7:0];
        ADDR_IRQ_MASK:        irq_mask <= bus_i.writedata[7:0];
        ADDR_COMPARATOR_CTRL: comparator_control_status <= bus_i.writedata[7:0];
        default: ;
      endcase
    end
  end

  // Shared holding register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      holding <= BYTE_RESET;
    end else if (wr_byte && (bus_i.address == ADDR_COUNT_HIGH ||
                             bus_i.address == ADDR_CAPTURE_HIGH ||
                             bus_i.address == ADDR_COMPARE_A_HIGH ||
                             bus_i.address == ADDR_COMPARE_B_HIGH)) begin
      holding <= bus_i.writedata[7:0];
    end else if (do_read && (bus_i.address == ADDR_COUNT_LOW ||
                             bus_i.address == ADDR_CAPTURE_LOW)) begin
      holding <= snap_high;
    end
  end

  // Compare registers, written through the holding register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      compare_a <= WORD_RESET;
      compare_b <= WORD_RESET;
    end else if (wr_byte && bus_i.address == ADDR_COMPARE_A_LOW) begin
      compare_a <= {holding, bus_i.writedata[7:0]};
    end else if (wr_byte && bus_i.address == ADDR_COMPARE_B_LOW) begin
      compare_b <= {holding, bus_i.writedata[7:0]};
    end
  end

  // Timer tick: prescaler taps or external clock edges
  logic [9:0] prescale;
  logic       ext_sync1;
  logic       ext_sync2;
  logic       ext_prev;
  logic       timer_tick;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      prescale  <= 10'h000;
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev  <= 1'b0;
    end else begin
      prescale  <= prescale + 10'h001;
      ext_sync1 <= external_clock_i;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end

  always_comb begin
    case (clock_select_field)
      CS_STOP:     timer_tick = 1'b0;
      CS_DIRECT:   timer_tick = 1'b1;
      CS_DIV8:     timer_tick = (prescale & PRESCALE_MASK_8) == PRESCALE_MASK_8;
      CS_DIV64:    timer_tick = (prescale & PRESCALE_MASK_64) == PRESCALE_MASK_64;
      CS_DIV256:   timer_tick = (prescale & PRESCALE_MASK_256) == PRESCALE_MASK_256;
      CS_DIV1024:  timer_tick = prescale == PRESCALE_MASK_1024;
      CS_EXT_FALL: timer_tick = ext_prev && !ext_sync2;
      CS_EXT_RISE: timer_tick = !ext_prev && ext_sync2;
      default:     timer_tick = 1'b0;
    endcase
  end

  // Counting sequence
  logic        at_bottom;
  logic        at_max;
  logic        at_top;
  logic [15:0] count_top;
  logic [15:0] next_count;
  count_dir_e  next_direction;
  logic        overflow_event;

  assign count_top = mode_top(waveform_mode_field, compare_a, capture_value);
  assign at_bottom = timer_count == COUNT_BOTTOM;
  assign at_max    = timer_count == COUNT_MAX;
  assign at_top    = timer_count == count_top;

  always_comb begin
    next_count     = timer_count;
    next_direction = direction;
    overflow_event = 1'b0;
    if (timer_tick) begin
      if (mode_dual(waveform_mode_field)) begin
        if (direction == DIR_UP && at_top) begin
          next_direction = DIR_DOWN;
          next_count     = timer_count - COUNT_ONE;
        end else if (direction == DIR_DOWN && at_bottom) begin
          next_direction = DIR_UP;
          next_count     = timer_count + COUNT_ONE;
          overflow_event = 1'b1;
        end else if (direction == DIR_DOWN) begin
          next_count = timer_count - COUNT_ONE;
        end else begin
          next_count = timer_count + COUNT_ONE;
        end
      end else begin
        next_direction = DIR_UP;
        if (at_top) begin
          next_count = COUNT_BOTTOM;
        end else begin
          next_count = timer_count + COUNT_ONE;
        end
        if (mode_fast(waveform_mode_field)) begin
          overflow_event = at_top;
        end else begin
          overflow_event = at_max;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      timer_count <= WORD_RESET;
      direction   <= DIR_UP;
    end else if (wr_byte && bus_i.address == ADDR_COUNT_LOW) begin
      timer_count <= {holding, bus_i.writedata[7:0]};
    end else begin
      timer_count <= next_count;
      direction   <= next_direction;
    end
  end

  // Capture source path: select, synchronise, filter, detect
  logic                      src_sync1;
  logic                      src_sync2;
  logic [FILTER_SAMPLES-2:0] filter_hist;
  logic                      filtered;
  logic                      detect_in;
  logic                      detect_prev;
  logic                      capture_event;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      src_sync1 <= 1'b0;
      src_sync2 <= 1'b0;
    end else begin
      // Switching the source here can look like an edge downstream
      src_sync1 <= comparator_capture_select ? comparator_output_i
                                             : capture_pin_i;
      src_sync2 <= src_sync1;
    end
  end

  // Output follows only when the newest sample and the three before agree
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      filter_hist <= '0;
      filtered    <= 1'b0;
    end else begin
      filter_hist <= {filter_hist[FILTER_SAMPLES-3:0], src_sync2};
      if (filter_hist == {(FILTER_SAMPLES-1){src_sync2}}) begin
        filtered <= src_sync2;
      end
    end
  end

  assign detect_in     = capture_filter_enable ? filtered : src_sync2;
  assign capture_event = (capture_edge_rising ? (detect_in && !detect_prev)
                                              : (!detect_in && detect_prev)) &&
                         !mode_capture_top(waveform_mode_field);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      detect_prev <= 1'b0;
    end else begin
      detect_prev <= detect_in;
    end
  end

  // Capture register: overwritten on every capture, writable as a limit
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      capture_value <= WORD_RESET;
    end else if (capture_event) begin
      capture_value <= timer_count;
    end else if (wr_byte && bus_i.address == ADDR_CAPTURE_LOW &&
                 mode_capture_top(waveform_mode_field)) begin
      capture_value <= {holding, bus_i.writedata[7:0]};
    end
  end

  // Flags: a hardware set in the clearing cycle wins over the clear
  logic flag_clear_write;
  assign flag_clear_write = wr_byte && bus_i.address == ADDR_IRQ_FLAGS;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      capture_flag <= 1'b0;
    end else if (capture_event) begin
      capture_flag <= 1'b1;
    end else if ((flag_clear_write && bus_i.writedata[IRQ_CAPTURE_BIT]) ||
                 capture_irq_ack_i) begin
      capture_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      overflow_flag <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag <= 1'b1;
    end else if ((flag_clear_write && bus_i.writedata[IRQ_OVERFLOW_BIT]) ||
                 overflow_irq_ack_i) begin
      overflow_flag <= 1'b0;
    end
  end

  // Interrupt requests are registered copies of flag and enable
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      capture_irq_o  <= 1'b0;
      overflow_irq_o <= 1'b0;
    end else begin
      capture_irq_o  <= capture_flag && capture_irq_enable;
      overflow_irq_o <= overflow_flag && overflow_irq_enable;
    end
  end

endmodule

// *** verification/counter16_monitor.sv ***
// Port checker for the 16-bit counter with input capture
`timescale 1ns/1ps
module counter16_monitor
  import counter16_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire avalon_req_s bus_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        capture_pin_i,
  input wire logic        comparator_output_i,
  input wire logic        external_clock_i,
  input wire logic        capture_irq_ack_i,
  input wire logic        overflow_irq_ack_i,
  input wire logic        capture_irq_o,
  input wire logic        overflow_irq_o
);
  logic [1:0] src_q;
  logic [4:0] quiet;
  logic       fin;
  // Cycles since a source moved; a capture in flight would mask a clear
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      src_q <= 2'h0;
      quiet <= 5'h00;
    end else begin
      src_q <= {capture_pin_i, comparator_output_i};
      if (src_q != {capture_pin_i, comparator_output_i}) quiet <= 5'h00;
      else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
    end
  end
  assign fin = !waitrequest_o && bus_i.write && bus_i.byteenable[0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_WAIT_ONE: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_ANSWER: assert property ((bus_i.read || bus_i.write) && waitrequest_o
    |=> !waitrequest_o)
    else $error("request not answered next cycle");
  AST_UPPER_ZERO: assert property (readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_READ_HOLD: assert property (!(bus_i.read && waitrequest_o) |=> $stable(readdata_o))
    else $error("read data changed without a read");
  AST_MASK_OFF: assert property (fin && bus_i.address == ADDR_IRQ_MASK &&
    !bus_i.writedata[IRQ_CAPTURE_BIT] |-> ##2 !capture_irq_o)
    else $error("capture interrupt stays up when disabled");
  AST_FLAG_W1C: assert property (fin && bus_i.address == ADDR_IRQ_FLAGS &&
    bus_i.writedata[IRQ_CAPTURE_BIT] && quiet > 5'd12 |-> ##2 !capture_irq_o)
    else $error("writing one did not clear capture flag");
  AST_FLAG_W0: assert property (fin && bus_i.address == ADDR_IRQ_FLAGS &&
    !bus_i.writedata[IRQ_CAPTURE_BIT] && capture_irq_o && !capture_irq_ack_i &&
    !$past(capture_irq_ack_i) && !$past(capture_irq_ack_i, 2) |-> ##2 capture_irq_o)
    else $error("writing zero cleared capture flag");
  AST_ACK_CLEAR: assert property (capture_irq_ack_i && quiet > 5'd12
    |-> ##3 !capture_irq_o)
    else $error("service acknowledge did not clear capture flag");
endmodule
bind counter16_input_capture counter16_monitor mon (
  .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .capture_pin_i(capture_pin_i),
  .comparator_output_i(comparator_output_i), .external_clock_i(external_clock_i),
  .capture_irq_ack_i(capture_irq_ack_i), .overflow_irq_ack_i(overflow_irq_ack_i),
  .capture_irq_o(capture_irq_o), .overflow_irq_o(overflow_irq_o));

// *** verification/capture_source_model.sv ***
// Capture pin and comparator output driven toward requested levels
`timescale 1ns/1ps
module capture_source_model (
  input  wire logic clock_i,
  input  wire logic pin_level_i,
  input  wire logic cmp_level_i,
  output logic      capture_pin_o,
  output logic      comparator_output_o
);
  initial {capture_pin_o, comparator_output_o} = 2'h0;
  // Levels move one clock after the request, as a port output bit would
  always @(posedge clock_i) begin
    capture_pin_o <= pin_level_i;
    comparator_output_o <= cmp_level_i;
  end
endmodule

// *** verification/counter16_input_capture_tb_top.sv ***
// Self-checking bench for the 16-bit counter with input capture
`timescale 1ns/1ps
module counter16_input_capture_tb_top import counter16_pkg::*; ;
  logic        clock_i, reset_i, pin_lvl, cmp_lvl, cap_ack, pin, cmp, cap_irq, ovf_irq;
  avalon_req_s req;
  logic [31:0] rdata;
  logic        waitrequest;
  logic [7:0]  q;
  logic [15:0] v, r;
  int          n_mismatch, total_checks, seed, cycles;
  counter16_input_capture DUT (.clock_i(clock_i), .reset_i(reset_i), .bus_i(req),
    .readdata_o(rdata), .waitrequest_o(waitrequest), .capture_pin_i(pin),
    .comparator_output_i(cmp), .external_clock_i(1'b0), .capture_irq_ack_i(cap_ack),
    .overflow_irq_ack_i(1'b0), .capture_irq_o(cap_irq), .overflow_irq_o(ovf_irq));
  capture_source_model src (.clock_i(clock_i), .pin_level_i(pin_lvl),
    .cmp_level_i(cmp_lvl), .capture_pin_o(pin), .comparator_output_o(cmp));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Long enough for every test with a wide margin
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{a, !wr, wr, {24'h000000, d}, 4'h1};
    do begin
      @(posedge clock_i);
    end while (waitrequest !== 1'b0);
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic rd16(input logic [5:0] a);
    xfer(1'b0, a, 8'h00);
    r[7:0] = q;
    xfer(1'b0, a + 6'h04, 8'h00);
    r[15:8] = q;
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] w);
    xfer(1'b1, a + 6'h04, w[15:8]);
    xfer(1'b1, a, w[7:0]);
  endtask
  task automatic drive(input logic p, input logic c, input int n);
    @(posedge clock_i);
    pin_lvl <= p;
    cmp_lvl <= c;
    repeat (n) @(posedge clock_i);
  endtask
  function automatic logic [7:0] ctrl_b(input logic [2:0] cs, input logic [3:0] m,
                                        input logic rise, input logic filt);
    return {filt, rise, 1'b0, m[3:2], cs};
  endfunction
  initial begin
    seed = 72;
    {n_mismatch, total_checks, cycles} = '0;
    reset_i = 1'b1;
    req = '0;
    {pin_lvl, cmp_lvl, cap_ack} = 3'h0;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    xfer(1'b0, ADDR_CONTROL_B, 8'h00);
    check(q, 16'h0000);
    xfer(1'b0, 6'h3c, 8'h00);
    check(q, 16'h0000);
    repeat (4) begin
      v = 16'($random(seed));
      wr16(ADDR_COUNT_LOW, v);
      repeat (10) @(posedge clock_i);
      rd16(ADDR_COUNT_LOW);
      check(r, v);
    end
    xfer(1'b1, ADDR_COUNT_HIGH, v[15:8]);
    xfer(1'b1, ADDR_COUNT_LOW, 8'h11);
    xfer(1'b1, ADDR_COMPARE_A_LOW, 8'h22);
    rd16(ADDR_COMPARE_A_LOW);
    check(r, {v[15:8], 8'h22});
    $display("holding register test done");
    wr16(ADDR_COUNT_LOW, 16'hfffe);
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_DIRECT, MODE_NORMAL, 1'b0, 1'b0));
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_NORMAL, 1'b0, 1'b0));
    rd16(ADDR_COUNT_LOW);
    check(r, 16'h0001);
    xfer(1'b0, ADDR_IRQ_FLAGS, 8'h00);
    check(q[0], 1'b1);
    xfer(1'b1, ADDR_IRQ_MASK, 8'h01);
    repeat (3) @(posedge clock_i);
    check(ovf_irq, 1'b1);
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h21);
    $display("counting test done");
    v = 16'($random(seed));
    wr16(ADDR_COUNT_LOW, v);
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_NORMAL, 1'b1, 1'b0));
    xfer(1'b1, ADDR_IRQ_MASK, 8'h20);
    drive(1'b1, 1'b0, 16);
    check(cap_irq, 1'b1);
    rd16(ADDR_CAPTURE_LOW);
    check(r, v);
    wr16(ADDR_COUNT_LOW, ~v);
    drive(1'b0, 1'b0, 16);
    rd16(ADDR_CAPTURE_LOW);
    check(r, v);
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h00);
    repeat (3) @(posedge clock_i);
    check(cap_irq, 1'b1);
    xfer(1'b1, ADDR_IRQ_MASK, 8'h00);
    repeat (3) @(posedge clock_i);
    check(cap_irq, 1'b0);
    xfer(1'b1, ADDR_IRQ_MASK, 8'h20);
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h20);
    repeat (3) @(posedge clock_i);
    check(cap_irq, 1'b0);
    drive(1'b1, 1'b0, 16);
    rd16(ADDR_CAPTURE_LOW);
    check(r, ~v);
    @(posedge clock_i) cap_ack <= 1'b1;
    @(posedge clock_i) cap_ack <= 1'b0;
    repeat (4) @(posedge clock_i);
    check(cap_irq, 1'b0);
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_NORMAL, 1'b0, 1'b0));
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h20);
    drive(1'b0, 1'b0, 16);
    check(cap_irq, 1'b1);
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_NORMAL, 1'b1, 1'b1));
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h20);
    drive(1'b1, 1'b0, 2);
    drive(1'b0, 1'b0, 16);
    check(cap_irq, 1'b0);
    drive(1'b1, 1'b0, 7);
    check(cap_irq, 1'b0);
    repeat (8) @(posedge clock_i);
    check(cap_irq, 1'b1);
    $display("capture and filter tests done");
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_NORMAL, 1'b1, 1'b0));
    xfer(1'b1, ADDR_COMPARATOR_CTRL, 8'h04);
    repeat (12) @(posedge clock_i);
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h20);
    drive(1'b1, 1'b1, 16);
    check(cap_irq, 1'b1);
    xfer(1'b1, ADDR_IRQ_FLAGS, 8'h20);
    drive(1'b0, 1'b1, 16);
    drive(1'b1, 1'b1, 16);
    check(cap_irq, 1'b0);
    xfer(1'b1, ADDR_COMPARATOR_CTRL, 8'h00);
    xfer(1'b1, ADDR_CONTROL_A, 8'h00);
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_CTC_CAPTURE, 1'b1, 1'b0));
    v = 16'($random(seed));
    wr16(ADDR_CAPTURE_LOW, v);
    rd16(ADDR_CAPTURE_LOW);
    check(r, v);
    drive(1'b0, 1'b1, 16);
    drive(1'b1, 1'b1, 16);
    check(cap_irq, 1'b0);
    xfer(1'b1, ADDR_CONTROL_B, ctrl_b(CS_STOP, MODE_NORMAL, 1'b1, 1'b0));
    wr16(ADDR_CAPTURE_LOW, ~v);
    rd16(ADDR_CAPTURE_LOW);
    check(r, v);
    $display("source and mode tests done");
    final_report();
  end
endmodule
